// ### common/pss_defines.vh
// Purpose: constants for the pcm slot, phase and strobe control block
// Assumes: AXI4-Lite byte addresses, one aligned 32-bit word per register
// Notes: included by rtl/pss_ctrl.v only
//
// Notes on behaviour
// (RULE_01) highway bit clock is delayed against frame sync by a programmable amount
// (RULE_02) transmit and receive have own shift; each acts alike on highways 0 and 1
// (RULE_03) phase register is write-only and clears to zero at reset
// (RULE_04) shift codes 000..101 give 2..7, 110 gives 0, 111 gives 1
// (RULE_05) transmit shift in bits 5..3, receive shift in bits 2..0, bits 7..6 ignored
// (RULE_06) each slot entry ties one port line and one channel/direction to a highway
// (RULE_07) mode 11 none, 10 highway 1, 01 highway 0, 00 processor transfer
// (RULE_08) transfer mode bits sit in bits 7 and 6 of each slot entry
// (RULE_09) software writes low six entry bits from time slot and clock shift
// (RULE_10) a programmable frame-synchronous signaling strobe output is driven
// (RULE_11) while strobe is active the six spare signaling bits go to expansion logic
// (RULE_12) strobe configuration is read/write and resets to zero, strobe inactive
// (RULE_13) source 0: strobe high when a direction enable and a channel select match
// (RULE_14) channel mode: low if both enables or both selects clear; all four set, high
// (RULE_15) source 1 fixed span: six bits, always high at bit 0 both directions
// (RULE_16) span nine bits: transmit always on bits 2..0, receive on bits 1..0
// (RULE_17) each set position bit adds a receive position; transmit low there
// (RULE_18) strobe is the enable of an external three-state expansion driver
// (RULE_19) software also programs transmit strobe for listed patterns to avoid contention; the code inverts the position bits for transmit instead
// (RULE_20) signaling byte: bits 7..5 signals, 4..1 programmable pins, 0 expansion bit
`ifndef PSS_DEFINES_VH
`define PSS_DEFINES_VH

// ==========================================================
// register map
`define PSS_ADDR_PHASE 8'h00
`define PSS_ADDR_STROBE 8'h04
`define PSS_ADDR_STATUS 8'h08
`define PSS_ADDR_SLOT_BASE 8'h80
`define PSS_SLOT_SEL_BIT 7

// ==========================================================
// field positions
`define PSS_TX_SHIFT_HI 5
`define PSS_TX_SHIFT_LO 3
`define PSS_RX_SHIFT_HI 2
`define PSS_RX_SHIFT_LO 0
`define PSS_MODE_HI 7
`define PSS_MODE_LO 6
`define PSS_SLOT_HI 5
`define PSS_SLOT_LO 0
`define PSS_SCR_RX_EN 7
`define PSS_SCR_TX_EN 6
`define PSS_SCR_CHA 5
`define PSS_SCR_CHB 4
`define PSS_SCR_POS_HI 7
`define PSS_SCR_POS_LO 4
`define PSS_SCR_SRC 3
`define PSS_SCR_FIXED 2

// ==========================================================
// codes and reset values
`define PSS_MODE_NONE 2'b11
`define PSS_MODE_HW1 2'b10
`define PSS_MODE_HW0 2'b01
`define PSS_MODE_CPU 2'b00
`define PSS_PHASE_RST 8'h00
`define PSS_STROBE_RST 8'h00
`define PSS_SLOT_RST 8'hc0
`define PSS_SHIFT_BIAS 3'h2
`define PSS_RESP_OKAY 2'b00
`define PSS_RESP_SLVERR 2'b10

// ==========================================================
// strobe spans and positions
`define PSS_FIXED_SPAN 6
`define PSS_FREE_SPAN 9
`define PSS_FIXED_POS_BASE 1
`define PSS_FREE_POS_BASE 3
`define PSS_TX_ALWAYS_TOP 2
`define PSS_RX_ALWAYS_TOP 1

`endif

// ### rtl/pss_ctrl.v
// Purpose: highway phase shift, slot assignment table and signaling strobe
// Assumes: highway clock and frame sync arrive unsynchronised on pins
// Notes: register access over AXI4-Lite, one write and one read at a time
`timescale 1ns/10ps
`include "pss_defines.vh"

module pss_ctrl #(
  parameter LINES = 8,
  parameter DIRS = 4,
  parameter CNT_W = 9
) (
  input wire aclk, // 250 MHz system clock
  input wire aresetn, // synchronous reset, active low
  input wire [7:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output reg s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte enables
  input wire s_axi_wvalid, // write data valid
  output reg s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [7:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output reg s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire highway_clk, // highway bit clock pin
  input wire frame_sync_pulse, // frame sync pin, active high
  input wire sig_window, // signaling bits of a channel are on the line
  input wire sig_dir_tx, // 1 transmit, 0 receive signaling byte
  input wire sig_chan_b, // 1 second channel, 0 first channel
  input wire [3:0] sig_bit_pos, // position within the signaling bits
  output reg signaling_strobe_q, // expansion strobe / driver enable
  output reg tx_frame_q, // one-cycle pulse: shifted transmit frame start
  output reg rx_frame_q, // one-cycle pulse: shifted receive frame start
  output reg [CNT_W-1:0] tx_bit_q, // bit count on the shifted transmit clock
  output reg [CNT_W-1:0] rx_bit_q, // bit count on the shifted receive clock
  output reg [LINES*DIRS-1:0] xfer_hw0_q, // entry active now on highway 0
  output reg [LINES*DIRS-1:0] xfer_hw1_q, // entry active now on highway 1
  output reg [LINES*DIRS-1:0] xfer_cpu_q // entry active now for processor
);

  // ==========================================================
  // helpers
  function [2:0] shift_of;
    input [2:0] code;
    begin
      shift_of = code + `PSS_SHIFT_BIAS; // RULE_04
    end
  endfunction

  // ==========================================================
  // registers
  reg [7:0] phase_q;
  reg [7:0] strobe_cfg_q;
  reg [7:0] slot_q [0:LINES*DIRS-1];
  reg aw_held_q;
  reg w_held_q;
  reg [7:0] aw_addr_q;
  reg [7:0] w_data_q;
  reg w_lane_q;
  reg hc_s1_q, hc_s2_q, hc_s3_q;
  reg fs_s1_q, fs_s2_q, fs_s3_q;
  reg hc_lvl_q;
  reg fs_lvl_q;
  reg [CNT_W-1:0] bit_cnt_q;
  reg [CNT_W-1:0] bit_cnt_d;
  reg strobe_d;
  reg [7:0] rd_data;
  reg rd_ok;
  integer i;
  integer j;

  wire [2:0] tx_shift = shift_of(phase_q[`PSS_TX_SHIFT_HI:`PSS_TX_SHIFT_LO]); // RULE_05
  wire [2:0] rx_shift = shift_of(phase_q[`PSS_RX_SHIFT_HI:`PSS_RX_SHIFT_LO]); // RULE_05
  // an edge counts only once stages two and three agree, so a runt seen by one stage is dropped
  wire clk_rise = hc_s2_q & hc_s3_q & ~hc_lvl_q;
  wire sync_rise = fs_s2_q & fs_s3_q & ~fs_lvl_q;
  wire do_write = aw_held_q & w_held_q & ~s_axi_bvalid;
  wire wr_slot = aw_addr_q[`PSS_SLOT_SEL_BIT];
  wire [4:0] wr_idx = aw_addr_q[6:2];
  wire [4:0] rd_idx = s_axi_araddr[6:2];

  // ==========================================================
  // write channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PSS_RESP_OKAY;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
      phase_q <= `PSS_PHASE_RST; // RULE_03
      strobe_cfg_q <= `PSS_STROBE_RST; // RULE_12
      for (i = 0; i < LINES*DIRS; i = i + 1) begin
        slot_q[i] <= `PSS_SLOT_RST;
      end
    end else begin
      // address and data are taken in either order and held until both are in
      s_axi_awready <= ~aw_held_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_held_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `PSS_RESP_OKAY;
        if (wr_slot) begin
          if (w_lane_q) begin
            slot_q[wr_idx] <= w_data_q; // RULE_06 RULE_09
          end
        end else if (aw_addr_q == `PSS_ADDR_PHASE) begin
          if (w_lane_q) begin
            phase_q <= w_data_q; // RULE_03
          end
        end else if (aw_addr_q == `PSS_ADDR_STROBE) begin
          if (w_lane_q) begin
            strobe_cfg_q <= w_data_q; // RULE_12
          end
        end else if (aw_addr_q != `PSS_ADDR_STATUS) begin
          s_axi_bresp <= `PSS_RESP_SLVERR;
        end else begin
          // status is read-only; a write there is accepted and dropped
          s_axi_bresp <= `PSS_RESP_OKAY;
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // read channel
  always @* begin
    rd_data = 8'h00;
    rd_ok = 1'b1;
    if (s_axi_araddr[`PSS_SLOT_SEL_BIT]) begin
      rd_data = slot_q[rd_idx];
    end else begin
      case (s_axi_araddr)
        // phase register is write-only and reads as zero
        `PSS_ADDR_PHASE: rd_data = 8'h00; // RULE_03
        `PSS_ADDR_STROBE: rd_data = strobe_cfg_q; // RULE_12
        `PSS_ADDR_STATUS: rd_data = {5'h00, tx_shift};
        default: rd_ok = 1'b0;
      endcase
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PSS_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_data};
        s_axi_rresp <= rd_ok ? `PSS_RESP_OKAY : `PSS_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // pin synchronisers and frame bit count
  always @(posedge aclk) begin
    if (!aresetn) begin
      hc_s1_q <= 1'b0;
      hc_s2_q <= 1'b0;
      hc_s3_q <= 1'b0;
      fs_s1_q <= 1'b0;
      fs_s2_q <= 1'b0;
      fs_s3_q <= 1'b0;
      hc_lvl_q <= 1'b0;
      fs_lvl_q <= 1'b0;
    end else begin
      hc_s1_q <= highway_clk;
      hc_s2_q <= hc_s1_q;
      hc_s3_q <= hc_s2_q;
      fs_s1_q <= frame_sync_pulse;
      fs_s2_q <= fs_s1_q;
      fs_s3_q <= fs_s2_q;
      if (hc_s2_q == hc_s3_q) begin
        hc_lvl_q <= hc_s3_q;
      end
      if (fs_s2_q == fs_s3_q) begin
        fs_lvl_q <= fs_s3_q;
      end
    end
  end

  always @* begin
    bit_cnt_d = bit_cnt_q;
    if (sync_rise) begin
      bit_cnt_d = {CNT_W{1'b0}};
    end else if (clk_rise) begin
      bit_cnt_d = bit_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // shifted clocks: the frame seen by each direction starts shift bit periods
  // after the sync pulse, the same for both highways
  always @(posedge aclk) begin
    if (!aresetn) begin
      bit_cnt_q <= {CNT_W{1'b0}};
      tx_bit_q <= {CNT_W{1'b0}};
      rx_bit_q <= {CNT_W{1'b0}};
      tx_frame_q <= 1'b0;
      rx_frame_q <= 1'b0;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      tx_bit_q <= bit_cnt_d - {{(CNT_W-3){1'b0}}, tx_shift}; // RULE_01 RULE_02
      rx_bit_q <= bit_cnt_d - {{(CNT_W-3){1'b0}}, rx_shift}; // RULE_01 RULE_02
      tx_frame_q <= (sync_rise | clk_rise) &
                    (bit_cnt_d == {{(CNT_W-3){1'b0}}, tx_shift}); // RULE_01
      rx_frame_q <= (sync_rise | clk_rise) &
                    (bit_cnt_d == {{(CNT_W-3){1'b0}}, rx_shift}); // RULE_01
    end
  end

  // ==========================================================
  // slot table lookup
  // the low six bits are compared with the current slot of the entry's direction;
  // software folds the clock shift into that value
  always @(posedge aclk) begin
    if (!aresetn) begin
      xfer_hw0_q <= {LINES*DIRS{1'b0}};
      xfer_hw1_q <= {LINES*DIRS{1'b0}};
      xfer_cpu_q <= {LINES*DIRS{1'b0}};
    end else begin
      for (j = 0; j < LINES*DIRS; j = j + 1) begin
        // entries 0..15 are receive (index/LINES 0,1), 16..31 transmit
        if (slot_q[j][`PSS_SLOT_HI:`PSS_SLOT_LO] ==
            ((j >= 2*LINES) ? tx_bit_q[8:3] : rx_bit_q[8:3])) begin // RULE_06 RULE_09
          xfer_hw0_q[j] <= slot_q[j][`PSS_MODE_HI:`PSS_MODE_LO] == `PSS_MODE_HW0; // RULE_07 RULE_08
          xfer_hw1_q[j] <= slot_q[j][`PSS_MODE_HI:`PSS_MODE_LO] == `PSS_MODE_HW1; // RULE_07 RULE_08
          xfer_cpu_q[j] <= slot_q[j][`PSS_MODE_HI:`PSS_MODE_LO] == `PSS_MODE_CPU; // RULE_07 RULE_08
        end else begin
          xfer_hw0_q[j] <= 1'b0;
          xfer_hw1_q[j] <= 1'b0;
          xfer_cpu_q[j] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // signaling strobe
  // tx and rx share the position bits; at each position a position bit covers, the tx strobe is the
  // inverse of the rx one, so software programs a single pattern
  always @* begin
    strobe_d = 1'b0;
    if (sig_window) begin
      if (!strobe_cfg_q[`PSS_SCR_SRC]) begin
        strobe_d = (sig_dir_tx ? strobe_cfg_q[`PSS_SCR_TX_EN] : strobe_cfg_q[`PSS_SCR_RX_EN]) &
                   (sig_chan_b ? strobe_cfg_q[`PSS_SCR_CHB] : strobe_cfg_q[`PSS_SCR_CHA]); // RULE_13 RULE_14
      end else if (strobe_cfg_q[`PSS_SCR_FIXED]) begin
        if (sig_bit_pos == 4'h0) begin
          strobe_d = 1'b1; // RULE_15
        end else if (sig_bit_pos < `PSS_FIXED_SPAN) begin
          strobe_d = sig_dir_tx ^ strobe_cfg_q[`PSS_SCR_POS_LO + sig_bit_pos - 4'h1]; // RULE_17
          if (sig_bit_pos == `PSS_FIXED_SPAN - 1) begin
            strobe_d = 1'b0; // RULE_15
          end
        end
      end else begin
        if (sig_dir_tx && sig_bit_pos <= `PSS_TX_ALWAYS_TOP) begin
          strobe_d = 1'b1; // RULE_16
        end else if (!sig_dir_tx && sig_bit_pos <= `PSS_RX_ALWAYS_TOP) begin
          strobe_d = 1'b1; // RULE_16
        end else if (sig_bit_pos >= `PSS_FREE_POS_BASE &&
                     sig_bit_pos < `PSS_FREE_POS_BASE + 4) begin
          strobe_d = sig_dir_tx ^
                     strobe_cfg_q[`PSS_SCR_POS_LO + sig_bit_pos - `PSS_FREE_POS_BASE]; // RULE_17
        end
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      signaling_strobe_q <= 1'b0; // RULE_12
    end else begin
      // this level enables the external expansion driver onto the port line
      signaling_strobe_q <= strobe_d; // RULE_10 RULE_11 RULE_18
    end
  end

endmodule

// ### sim/pss_ctrl_props.sv
// Purpose: port checks for pss_ctrl
// Assumes: config writes land in the block on the same edge that raises bvalid
// Notes: strobe checks other than win_low_a skip cycles near a bus write
`timescale 1ns/10ps
module pss_ctrl_props #(
  parameter LINES = 8,
  parameter DIRS = 4
) (
  input wire aclk, // clock
  input wire aresetn, // reset
  input wire [7:0] s_axi_awaddr, // aw
  input wire s_axi_awvalid, // aw
  input wire s_axi_awready, // aw
  input wire [31:0] s_axi_wdata, // w
  input wire s_axi_wvalid, // w
  input wire s_axi_wready, // w
  input wire s_axi_bvalid, // b
  input wire s_axi_bready, // b
  input wire [7:0] s_axi_araddr, // ar
  input wire s_axi_arvalid, // ar
  input wire s_axi_arready, // ar
  input wire [31:0] s_axi_rdata, // r
  input wire s_axi_rvalid, // r
  input wire sig_window, // sig
  input wire sig_dir_tx, // sig
  input wire sig_chan_b, // sig
  input wire [3:0] sig_bit_pos, // sig
  input wire signaling_strobe_q, // strobe
  input wire tx_frame_q, // frame
  input wire [LINES*DIRS-1:0] xfer_hw0_q, // hw0
  input wire [LINES*DIRS-1:0] xfer_hw1_q // hw1
);
  // ==========================================================
  // shadow of the strobe configuration, snooped off the bus
  reg [7:0] aw_q, wd_q, ar_q, cfg_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 8'h00;
      wd_q <= 8'h00;
      ar_q <= 8'h00;
      cfg_q <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[7:0];
      if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
      if (s_axi_bvalid && s_axi_bready && aw_q == 8'h04) cfg_q <= wd_q;
    end
  end
  // the shadow lags the block during a write, so those cycles are left out
  wire quiet = !(s_axi_awvalid | s_axi_wvalid | s_axi_bvalid) && sig_window;
  wire en = sig_dir_tx ? cfg_q[6] : cfg_q[7];
  wire ch = sig_chan_b ? cfg_q[4] : cfg_q[5];
  wire [3:0] rel = sig_bit_pos - (cfg_q[2] ? 4'h1 : 4'h3);
  wire pbit = cfg_q[{1'b1, rel[1:0]}];
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // assertions
  win_low_a: assert property (!sig_window |=> !signaling_strobe_q)
    else $error("strobe high outside window");
  chan_src_a: assert property (quiet && !cfg_q[3] |=> signaling_strobe_q == $past(en && ch))
    else $error("channel strobe wrong");
  fixed_bit0_a: assert property (quiet && cfg_q[3] && cfg_q[2] && sig_bit_pos == 4'h0
    |=> signaling_strobe_q)
    else $error("fixed span bit0 low");
  free_low_a: assert property (quiet && cfg_q[3] && !cfg_q[2]
    && sig_bit_pos <= (sig_dir_tx ? 4'h2 : 4'h1) |=> signaling_strobe_q)
    else $error("free span low bits not high");
  pos_bit_a: assert property (quiet && cfg_q[3] && rel < 4'h4
    |=> signaling_strobe_q == $past(pbit ^ sig_dir_tx))
    else $error("position bit strobe wrong");
  phase_read_a: assert property (s_axi_rvalid && ar_q == 8'h00 |-> s_axi_rdata == 32'h0)
    else $error("phase register readable");
  mode_excl_a: assert property (!(|(xfer_hw0_q & xfer_hw1_q)))
    else $error("entry on both highways");
  frame_pulse_a: assert property (tx_frame_q |=> !tx_frame_q)
    else $error("frame pulse too long");
  cover property (quiet && cfg_q[3] ##1 signaling_strobe_q);
  cover property (|xfer_hw0_q);
  cover property (tx_frame_q);
endmodule

// ### sim/pss_link_peer.sv
// Purpose: highway side peer driving frame sync and bit clock
// Assumes: 64 ns bit clock, unrelated to aclk
// Notes: clock stands low outside frames
`timescale 1ns/10ps
module pss_link_peer (
  output logic highway_clk, // bit clock
  output logic frame_sync_pulse // frame sync
);
  initial begin
    highway_clk = 1'b0;
    frame_sync_pulse = 1'b0;
  end
  // ==========================================================
  // one frame start followed by n bit clock rises
  task frame(input int n);
    frame_sync_pulse = 1'b1;
    #41.3;
    frame_sync_pulse = 1'b0;
    #13.1;
    repeat (n) begin
      highway_clk = 1'b1;
      #32;
      highway_clk = 1'b0;
      #32;
    end
  endtask
endmodule

// ### sim/tb_pss_ctrl.sv
// Purpose: self-checking bench for pss_ctrl
// Assumes: bus answers are looked at on the falling edge before they are taken
// Notes: every task starts and ends on a rising edge
`timescale 1ns/10ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin fails++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module tb_pss_ctrl;
  reg aclk = 1'b0, aresetn = 1'b0;
  reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'h1, sig_bit_pos = 4'h0;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  reg s_axi_rready = 0, sig_window = 0, sig_dir_tx = 0, sig_chan_b = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire signaling_strobe_q, tx_frame_q, rx_frame_q, highway_clk, frame_sync_pulse;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, xfer_hw0_q, xfer_hw1_q, xfer_cpu_q;
  wire [8:0] tx_bit_q, rx_bit_q;
  int fails = 0, samples_checked = 0, cyc = 0;
  int tx_pulses = 0, rx_pulses = 0;
  reg [31:0] d;
  reg [1:0] r;
  always #2 aclk = ~aclk;
  pss_ctrl i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .highway_clk,
    .frame_sync_pulse, .sig_window, .sig_dir_tx, .sig_chan_b, .sig_bit_pos,
    .signaling_strobe_q, .tx_frame_q, .rx_frame_q, .tx_bit_q, .rx_bit_q,
    .xfer_hw0_q, .xfer_hw1_q, .xfer_cpu_q);
  pss_link_peer i_peer (.highway_clk, .frame_sync_pulse);
  // ==========================================================
  // bus, strobe and closing tasks
  task end_sim;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (tx_frame_q === 1'b1) tx_pulses <= tx_pulses + 1;
    if (rx_frame_q === 1'b1) rx_pulses <= rx_pulses + 1;
    if (cyc == 30000) begin
      fails++;
      end_sim;
    end
  end
  task wr(input [7:0] a, input [7:0] v);
    reg ta, tw, da, dw;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    da = 0;
    dw = 0;
    while (!(da && dw)) begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      @(posedge aclk);
      if (ta) begin da = 1; s_axi_awvalid <= 1'b0; end
      if (tw) begin dw = 1; s_axi_wvalid <= 1'b0; end
    end
    do begin @(negedge aclk); ta = s_axi_bvalid; r = s_axi_bresp; @(posedge aclk); end
    while (ta !== 1'b1);
    s_axi_bready <= 1'b0;
    // one edge apart, so a following write never sets bready in the same step
    @(posedge aclk);
  endtask
  task rd(input [7:0] a);
    reg t;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin @(negedge aclk); t = s_axi_arready; @(posedge aclk); end while (t !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      t = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
    end while (t !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task sig(input tx, input b, input [3:0] p, input w, input e);
    sig_dir_tx <= tx;
    sig_chan_b <= b;
    sig_bit_pos <= p;
    sig_window <= w;
    @(posedge aclk);
    @(negedge aclk);
    `CHK("strobe", e, signaling_strobe_q)
    @(posedge aclk);
  endtask
  function bit ex(input [7:0] c, input tx, input [3:0] p);
    reg [3:0] q;
    q = p - (c[2] ? 4'h1 : 4'h3);
    if (p <= (c[2] ? 4'h0 : (tx ? 4'h2 : 4'h1))) return 1'b1;
    if (q < 4'h4) return c[{1'b1, q[1:0]}] ^ tx;
    return 1'b0;
  endfunction
  // ==========================================================
  // scenarios
  task t_reset;
    rd(8'h04); `CHK("cfg reset", 32'h0, d)
    wr(8'h00, 8'h2d); `CHK("wr okay", 2'b00, r)
    rd(8'h00); `CHK("phase read", 32'h0, d)
    rd(8'h08); `CHK("phase took", 32'h7, d)
    rd(8'h80); `CHK("entry reset", 32'hc0, d)
    rd(8'h40); `CHK("unmapped", 2'b10, r)
    `CHK("unmapped data", 32'h0, d)
    wr(8'h40, 8'h11); `CHK("unmapped wr", 2'b10, r)
    s_axi_wstrb <= 4'he;
    wr(8'h04, 8'hff);
    s_axi_wstrb <= 4'h1;
    rd(8'h04); `CHK("lane off", 32'h0, d)
  endtask
  task t_chan;
    for (int c = 0; c < 16; c++) begin
      wr(8'h04, {c[3:0], 4'h0});
      rd(8'h04); `CHK("cfg rw", {24'h0, c[3:0], 4'h0}, d)
      for (int k = 0; k < 4; k++) begin
        sig(k[1], k[0], 4'h0, 1'b1, (k[1] ? c[2] : c[3]) & (k[0] ? c[0] : c[1]));
      end
      sig(1'b0, 1'b0, 4'h0, 1'b0, 1'b0);
    end
  endtask
  task t_bits;
    reg [23:0] nibs;
    reg [7:0] c;
    // patterns that need the transmit strobe programmed too, plus one more
    nibs = 24'h5f7310;
    for (int f = 0; f < 2; f++) begin
      for (int n = 0; n < 6; n++) begin
        c = {nibs[4*n +: 4], 1'b1, f[0], 2'b01};
        wr(8'h04, c);
        for (int p = 0; p < 16; p++) begin
          sig(1'b0, p[0], p[3:0], 1'b1, ex(c, 1'b0, p[3:0]));
          sig(1'b1, p[1], p[3:0], 1'b1, ex(c, 1'b1, p[3:0]));
        end
      end
    end
    sig(1'b0, 1'b0, 4'h0, 1'b0, 1'b0);
  endtask
  task t_phase;
    int n0, n1;
    for (int c = 0; c < 8; c++) begin
      wr(8'h00, {2'b11, c[2:0], ~c[2:0]});
      rd(8'h08); `CHK("tx shift", 3'(c + 2), d[2:0])
      n0 = tx_pulses;
      n1 = rx_pulses;
      i_peer.frame(10);
      repeat (12) @(posedge aclk);
      `CHK("tx count", 9'(10 - ((c + 2) % 8)), tx_bit_q)
      `CHK("rx count", 9'(10 - ((9 - c) % 8)), rx_bit_q)
      `CHK("tx frame", n0 + 1, tx_pulses)
      `CHK("rx frame", n1 + 1, rx_pulses)
    end
  endtask
  task t_slot;
    wr(8'h00, 8'h36);
    wr(8'hc0, 8'h41);
    wr(8'h84, 8'h81);
    wr(8'h8c, 8'h01);
    rd(8'hc0); `CHK("entry rw", 32'h41, d)
    i_peer.frame(8);
    repeat (12) @(posedge aclk);
    `CHK("hw0", 32'h0001_0000, xfer_hw0_q)
    `CHK("hw1", 32'h2, xfer_hw1_q)
    `CHK("cpu", 32'h8, xfer_cpu_q)
    i_peer.frame(16);
    repeat (12) @(posedge aclk);
    `CHK("hw0 off", 32'h0, xfer_hw0_q)
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_chan;
    t_bits;
    t_phase;
    t_slot;
    end_sim;
  end
endmodule
bind pss_ctrl pss_ctrl_props #(.LINES(LINES), .DIRS(DIRS)) i_props (.aclk, .aresetn,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .sig_window, .sig_dir_tx, .sig_chan_b,
  .sig_bit_pos, .signaling_strobe_q, .tx_frame_q, .xfer_hw0_q, .xfer_hw1_q);
